// ---- rtl/pss_pkg.sv ----
// constants, register map and snapshot entry layout of the snapshot selector
// Operation
// - eight independent snapshots per preset, any one selectable as active
// - snapshot holds block bypass, alternate choice, main level, insert-path level
// - switching applies stored bypass, alternate and levels at once, audio uninterrupted
// - new preset marks every block engaged in all eight snapshots
// - alternate choice exists only for amp, cab, chorus, delay, drive, etc. blocks
// - direct select uses configurable controller number, default 34
// - direct select activates snapshot (value mod 8) plus one
// - footswitch opening loads snapshot one, closure snapshot eight, like values 0 and 127
// - step up and step down controller numbers, defaults 123 and 124
// - step acts only for values 64-127; 0-63 ignored without change
// - custom mapping turns program change into target preset and snapshot
// - suppression on: change mapping to loaded preset only switches snapshot
// - mapping table edits act at once, no store needed
// - revert off: edits survive snapshot changes until preset load or reload
// - revert on: leaving a snapshot discards its unsaved edits
// - store commits all eight snapshots of the preset together
// - input-only bypass stops feeding block but lets existing tails decay
// - main level scales the whole output including carried-over tails
// - active snapshot number shown on recall and layout displays
// - every snapshot change is reported to the attached foot controller
package pss_pkg;

	// ========================================================================
	// snapshot entry layout
	localparam int          NUM_SNAPSHOTS = 8;
	localparam int          SNAP_W        = 3;
	localparam int          NUM_BLOCKS    = 16;
	localparam int          LEVEL_W       = 8;
	localparam int          ENTRY_W       = 48;
	localparam int          BYP_LSB       = 0;
	localparam int          ALT_LSB       = 16;
	localparam int          MAIN_LSB      = 32;
	localparam int          LOOP_LSB      = 40;
	// blocks 0..9: amp, cab, chorus, delay, drive, flanger, pitch, phaser, reverb, wah
	localparam logic [15:0] ALT_CAPABLE_MASK = 16'h03FF;
	localparam logic [7:0]  RESET_LEVEL      = 8'h80;
	localparam logic [2:0]  FIRST_SNAPSHOT   = 3'h0;
	localparam logic [2:0]  LAST_SNAPSHOT    = 3'h7;

	// ========================================================================
	// controller defaults and thresholds
	localparam logic [6:0] RESET_SELECT_CC = 7'h22;
	localparam logic [6:0] RESET_UP_CC     = 7'h7B;
	localparam logic [6:0] RESET_DOWN_CC   = 7'h7C;
	localparam logic [6:0] CC_VALUE_MIN    = 7'h00;
	localparam logic [6:0] CC_VALUE_MAX    = 7'h7F;
	localparam int         SYNC_STAGES     = 3;

	// ========================================================================
	// register map (byte addresses) and fields
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] CCNUM_OFFSET  = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] CMD_OFFSET    = 8'h0C;
	localparam logic [7:0] BYPASS_OFFSET = 8'h10;
	localparam logic [7:0] ALT_OFFSET    = 8'h14;
	localparam logic [7:0] LEVEL_OFFSET  = 8'h18;
	localparam logic [7:0] MUTE_OFFSET   = 8'h1C;
	localparam logic [7:0] MAP_OFFSET    = 8'h20;
	localparam int         CTRL_REVERT   = 0;
	localparam int         CTRL_SUPPRESS = 1;
	localparam int         CTRL_CUSTOM   = 2;
	localparam int         CMD_STORE     = 0;
	localparam int         CMD_CREATE    = 1;
	localparam int         CMD_RELOAD    = 2;
	localparam int         CMD_PANEL     = 3;
	localparam int         CMD_PANEL_LSB = 4;
	localparam int         CMD_LOAD      = 7;
	localparam int         CMD_PRESET_LSB = 8;
	localparam int         MAP_TO_LSB    = 8;
	localparam int         MAP_SNAP_LSB  = 16;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ---- rtl/pss_snapshot_selector.sv ----
// snapshot selector: midi/panel/footswitch selection, edit store and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module pss_snapshot_selector (
	input  wire logic        core_clk,
	input  wire logic        srst,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// decoded midi messages
	input  wire logic        midi_cc_valid,
	input  wire logic [6:0]  midi_cc_number,
	input  wire logic [6:0]  midi_cc_value,
	input  wire logic        midi_pc_valid,
	input  wire logic [6:0]  midi_pc_number,
	// local_footswitch_input jack pin
	input  wire logic        local_footswitch_input,
	// applied snapshot contents
	output logic [15:0]      block_bypass,
	output logic [15:0]      block_alt_select,
	output logic [15:0]      block_input_mute,
	output logic [15:0]      block_output_mute,
	output logic [7:0]       main_level,
	output logic [7:0]       external_insert_path_level,
	// display, foot controller report, preset engine
	output logic [3:0]       display_snapshot_number,
	output logic             snapshot_report_valid,
	output logic [3:0]       snapshot_report_number,
	output logic             preset_load_valid,
	output logic [6:0]       preset_load_index,
	output logic             preset_store_valid
);

	// ========================================================================
	// functions
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [47:0] fresh_entry();
		logic [47:0] e;
		e = '0;
		e[pss_pkg::MAIN_LSB +: 8] = pss_pkg::RESET_LEVEL;
		e[pss_pkg::LOOP_LSB +: 8] = pss_pkg::RESET_LEVEL;
		return e;
	endfunction

	// ========================================================================
	// state
	logic [47:0] working [pss_pkg::NUM_SNAPSHOTS];
	logic [47:0] stored  [pss_pkg::NUM_SNAPSHOTS];
	logic [9:0]  map_table [128];
	logic [2:0]  active;
	logic [6:0]  current_preset;
	logic [2:0]  ctrl;
	logic [6:0]  select_cc;
	logic [6:0]  step_up_controller_number;
	logic [6:0]  step_down_controller_number;
	logic [15:0] silence_block_input_only;
	logic [6:0]  map_view;
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [2:0]  fs_sync;
	logic        fs_level;
	logic        fs_event;
	logic        change;
	logic [2:0]  next_active;
	logic        load;
	logic [6:0]  next_preset;
	logic        store_cmd;
	logic        create_cmd;
	logic [47:0] act_entry;

	// ========================================================================
	// axi4-lite write path: address and data taken in either order
	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pss_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= pss_pkg::MAP_OFFSET) ?
				pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ========================================================================
	// configuration registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl                        <= '0;
			select_cc                   <= pss_pkg::RESET_SELECT_CC;
			step_up_controller_number   <= pss_pkg::RESET_UP_CC;
			step_down_controller_number <= pss_pkg::RESET_DOWN_CC;
			silence_block_input_only    <= '0;
			map_view                    <= '0;
		end else if (do_write) begin
			case (aw_addr)
				pss_pkg::CTRL_OFFSET: begin
					ctrl <= 3'(merge_bytes({29'h0, ctrl}, w_data, w_strb));
				end
				pss_pkg::CCNUM_OFFSET: begin
					if (w_strb[0]) select_cc <= w_data[6:0];
					if (w_strb[1]) step_up_controller_number <= w_data[14:8];
					if (w_strb[2]) step_down_controller_number <= w_data[22:16];
				end
				pss_pkg::MUTE_OFFSET: begin
					silence_block_input_only <= 16'(merge_bytes({16'h0,
						silence_block_input_only}, w_data, w_strb));
				end
				pss_pkg::MAP_OFFSET: begin
					map_view <= w_data[6:0];
				end
				default: begin
				end
			endcase
		end
	end

	// table edits act on the next program change, nothing to commit
	always_ff @(posedge core_clk) begin
		if (do_write && aw_addr == pss_pkg::MAP_OFFSET) begin
			map_table[w_data[6:0]] <= {w_data[pss_pkg::MAP_SNAP_LSB +: 3],
				w_data[pss_pkg::MAP_TO_LSB +: 7]};
		end
	end

	// ========================================================================
	// local_footswitch_input jack: three stages, change accepted when last two agree
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fs_sync  <= '0;
			fs_level <= 1'b0;
		end else begin
			fs_sync <= {fs_sync[1:0], local_footswitch_input};
			if (fs_sync[1] == fs_sync[2] && fs_sync[2] != fs_level) begin
				fs_level <= fs_sync[2];
			end
		end
	end

	assign fs_event = (fs_sync[1] == fs_sync[2]) && (fs_sync[2] != fs_level);

	// ========================================================================
	// selection: preset commands, program change, cc select, step, local_footswitch_input, panel
	assign store_cmd  = do_write && aw_addr == pss_pkg::CMD_OFFSET &&
		w_data[pss_pkg::CMD_STORE];
	assign create_cmd = do_write && aw_addr == pss_pkg::CMD_OFFSET &&
		w_data[pss_pkg::CMD_CREATE];

	always_comb begin
		change      = 1'b0;
		next_active = active;
		load        = 1'b0;
		next_preset = current_preset;
		if (do_write && aw_addr == pss_pkg::CMD_OFFSET &&
			(w_data[pss_pkg::CMD_RELOAD] || w_data[pss_pkg::CMD_LOAD] ||
			w_data[pss_pkg::CMD_CREATE])) begin
			load        = 1'b1;
			next_active = pss_pkg::FIRST_SNAPSHOT;
			if (w_data[pss_pkg::CMD_LOAD]) begin
				next_preset = w_data[pss_pkg::CMD_PRESET_LSB +: 7];
			end
		end else if (midi_pc_valid) begin
			if (ctrl[pss_pkg::CTRL_CUSTOM]) begin
				next_preset = map_table[midi_pc_number][6:0];
				next_active = map_table[midi_pc_number][9:7];
			end else begin
				next_preset = midi_pc_number;
				next_active = pss_pkg::FIRST_SNAPSHOT;
			end
			// same preset with suppression: snapshot switch only, no reload
			load = !(ctrl[pss_pkg::CTRL_SUPPRESS] && next_preset == current_preset);
		end else if (midi_cc_valid && midi_cc_number == select_cc) begin
			next_active = midi_cc_value[2:0];
		end else if (midi_cc_valid && midi_cc_value[6] &&
			midi_cc_number == step_up_controller_number) begin
			if (active != pss_pkg::LAST_SNAPSHOT) begin
				next_active = active + 3'h1;
			end
		end else if (midi_cc_valid && midi_cc_value[6] &&
			midi_cc_number == step_down_controller_number) begin
			if (active != pss_pkg::FIRST_SNAPSHOT) begin
				next_active = active - 3'h1;
			end
		end else if (fs_event) begin
			// closed acts as value 127, open as value 0
			next_active = fs_sync[2] ? pss_pkg::CC_VALUE_MAX[2:0] :
				pss_pkg::CC_VALUE_MIN[2:0];
		end else if (do_write && aw_addr == pss_pkg::CMD_OFFSET &&
			w_data[pss_pkg::CMD_PANEL]) begin
			next_active = w_data[pss_pkg::CMD_PANEL_LSB +: 3];
		end
		change = load || (next_active != active);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			active         <= pss_pkg::FIRST_SNAPSHOT;
			current_preset <= '0;
		end else begin
			active         <= next_active;
			current_preset <= next_preset;
		end
	end

	// ========================================================================
	// snapshot storage: edits, revert, load, store, create
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < pss_pkg::NUM_SNAPSHOTS; i++) begin
				working[i] <= fresh_entry();
			end
		end else if (load) begin
			// pending edits dropped on preset load, reload or create; with revert on also on snapshot change
			for (int i = 0; i < pss_pkg::NUM_SNAPSHOTS; i++) begin
				working[i] <= create_cmd ? fresh_entry() : stored[i];
			end
		end else if (change && ctrl[pss_pkg::CTRL_REVERT]) begin
			working[active] <= stored[active];
		end else if (do_write) begin
			case (aw_addr)
				pss_pkg::BYPASS_OFFSET: begin
					working[active][pss_pkg::BYP_LSB +: 16] <= 16'(merge_bytes({16'h0,
						working[active][pss_pkg::BYP_LSB +: 16]}, w_data,
						w_strb));
				end
				pss_pkg::ALT_OFFSET: begin
					working[active][pss_pkg::ALT_LSB +: 16] <= 16'(merge_bytes({16'h0,
						working[active][pss_pkg::ALT_LSB +: 16]}, w_data,
						w_strb)) & pss_pkg::ALT_CAPABLE_MASK;
				end
				pss_pkg::LEVEL_OFFSET: begin
					working[active][pss_pkg::MAIN_LSB +: 16] <= 16'(merge_bytes({16'h0,
						working[active][pss_pkg::MAIN_LSB +: 16]}, w_data,
						w_strb));
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < pss_pkg::NUM_SNAPSHOTS; i++) begin
				stored[i] <= fresh_entry();
			end
		end else if (create_cmd) begin
			for (int i = 0; i < pss_pkg::NUM_SNAPSHOTS; i++) begin
				stored[i] <= fresh_entry();
			end
		end else if (store_cmd) begin
			for (int i = 0; i < pss_pkg::NUM_SNAPSHOTS; i++) begin
				stored[i] <= working[i];
			end
		end
	end

	// ========================================================================
	// applied outputs: no reset of audio state, only parameters move
	assign act_entry = working[active];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			block_bypass               <= '0;
			block_alt_select           <= '0;
			block_input_mute           <= '0;
			block_output_mute          <= '0;
			main_level                 <= pss_pkg::RESET_LEVEL;
			external_insert_path_level <= pss_pkg::RESET_LEVEL;
			display_snapshot_number    <= 4'h1;
		end else begin
			block_bypass     <= act_entry[pss_pkg::BYP_LSB +: 16];
			block_alt_select <= act_entry[pss_pkg::ALT_LSB +: 16] &
				pss_pkg::ALT_CAPABLE_MASK;
			// input-only bypass lets delay and reverb tails ring out
			block_input_mute  <= act_entry[pss_pkg::BYP_LSB +: 16] &
				silence_block_input_only;
			block_output_mute <= act_entry[pss_pkg::BYP_LSB +: 16] &
				~silence_block_input_only;
			// applied after the mix, so tails follow it too
			main_level                 <= act_entry[pss_pkg::MAIN_LSB +: 8];
			external_insert_path_level <= act_entry[pss_pkg::LOOP_LSB +: 8];
			display_snapshot_number    <= {1'b0, active} + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			snapshot_report_valid  <= 1'b0;
			snapshot_report_number <= 4'h1;
			preset_load_valid      <= 1'b0;
			preset_load_index      <= '0;
			preset_store_valid     <= 1'b0;
		end else begin
			snapshot_report_valid <= change;
			if (change) begin
				snapshot_report_number <= {1'b0, next_active} + 4'h1;
			end
			preset_load_valid  <= load;
			preset_load_index  <= next_preset;
			preset_store_valid <= store_cmd;
		end
	end

	// ========================================================================
	// axi4-lite read path
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= pss_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= pss_pkg::RESP_OKAY;
			case (s_axi_araddr)
				pss_pkg::CTRL_OFFSET:   s_axi_rdata <= {29'h0, ctrl};
				pss_pkg::CCNUM_OFFSET:  s_axi_rdata <= {9'h0, step_down_controller_number,
					1'b0, step_up_controller_number, 1'b0, select_cc};
				pss_pkg::STATUS_OFFSET: s_axi_rdata <= {17'h0, current_preset, 5'h0, active};
				pss_pkg::CMD_OFFSET:    s_axi_rdata <= '0;
				pss_pkg::BYPASS_OFFSET: s_axi_rdata <= {16'h0, act_entry[pss_pkg::BYP_LSB +: 16]};
				pss_pkg::ALT_OFFSET:    s_axi_rdata <= {16'h0, act_entry[pss_pkg::ALT_LSB +: 16]};
				pss_pkg::LEVEL_OFFSET:  s_axi_rdata <= {16'h0, act_entry[pss_pkg::MAIN_LSB +: 16]};
				pss_pkg::MUTE_OFFSET:   s_axi_rdata <= {16'h0, silence_block_input_only};
				pss_pkg::MAP_OFFSET:    s_axi_rdata <= {13'h0, map_table[map_view][9:7], 1'b0,
					map_table[map_view][6:0], 1'b0, map_view};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= pss_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ---- dv/pss_midi_model.sv ----
// midi sender standing in for the foot controller, plus the local_footswitch_input jack
`timescale 1ns/1ps
module pss_midi_model (
	input  wire logic core_clk,
	output logic      midi_cc_valid,
	output logic [6:0] midi_cc_number,
	output logic [6:0] midi_cc_value,
	output logic      midi_pc_valid,
	output logic [6:0] midi_pc_number,
	output logic      local_footswitch_input
);
	initial begin
		midi_cc_valid = 1'b0;
		midi_cc_number = 7'h55;
		midi_cc_value = 7'h2A;
		midi_pc_valid = 1'b0;
		midi_pc_number = 7'h2A;
		local_footswitch_input = 1'b0;
	end
	// ====
	// messages
	// idle fields flip to the inverse so nothing leans on stale data
	task automatic send_cc(input logic [6:0] num, input logic [6:0] val);
		@(posedge core_clk);
		midi_cc_valid <= 1'b1;
		midi_cc_number <= num;
		midi_cc_value <= val;
		@(posedge core_clk);
		midi_cc_valid <= 1'b0;
		midi_cc_number <= ~num;
		midi_cc_value <= ~val;
	endtask
	task automatic send_pc(input logic [6:0] num);
		@(posedge core_clk);
		midi_pc_valid <= 1'b1;
		midi_pc_number <= num;
		@(posedge core_clk);
		midi_pc_valid <= 1'b0;
		midi_pc_number <= ~num;
	endtask
	task automatic set_local_footswitch_input(input logic v);
		@(posedge core_clk);
		local_footswitch_input <= v;
	endtask
endmodule

// ---- dv/pss_monitor.sv ----
// port checker for the snapshot selector
`timescale 1ns/1ps
module pss_monitor (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        midi_cc_valid,
	input wire logic [6:0]  midi_cc_number,
	input wire logic [6:0]  midi_cc_value,
	input wire logic        midi_pc_valid,
	input wire logic [15:0] block_bypass,
	input wire logic [15:0] block_alt_select,
	input wire logic [15:0] block_input_mute,
	input wire logic [15:0] block_output_mute,
	input wire logic [3:0]  display_snapshot_number,
	input wire logic        snapshot_report_valid,
	input wire logic [3:0]  snapshot_report_number
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	logic cc_only;
	logic up_req;
	logic dn_req;
	assign cc_only = midi_cc_valid && !midi_pc_valid;
	assign up_req = cc_only && midi_cc_number == pss_pkg::RESET_UP_CC;
	assign dn_req = cc_only && midi_cc_number == pss_pkg::RESET_DOWN_CC;
	// ====
	// sequences
	// a quiet report line means the display already shows the active snapshot
	sequence s_up_mid;
		up_req && midi_cc_value[6] && !snapshot_report_valid && display_snapshot_number < 4'h8;
	endsequence
	sequence s_up_top;
		up_req && midi_cc_value[6] && !snapshot_report_valid && display_snapshot_number == 4'h8;
	endsequence
	sequence s_dn_bot;
		dn_req && midi_cc_value[6] && !snapshot_report_valid && display_snapshot_number == 4'h1;
	endsequence
	sequence s_select;
		cc_only && midi_cc_number == pss_pkg::RESET_SELECT_CC ##1 !(midi_cc_valid || midi_pc_valid);
	endsequence
	// ====
	// properties
	property p_step_up;
		s_up_mid |=> snapshot_report_valid
			&& snapshot_report_number == $past(display_snapshot_number) + 4'h1;
	endproperty
	property p_up_top;
		s_up_top |=> !snapshot_report_valid;
	endproperty
	property p_dn_bot;
		s_dn_bot |=> !snapshot_report_valid;
	endproperty
	property p_select;
		s_select |=> display_snapshot_number == {1'b0, $past(midi_cc_value[2:0], 2)} + 4'h1;
	endproperty
	property p_step_low;
		(up_req || dn_req) && !midi_cc_value[6] |=> !snapshot_report_valid;
	endproperty
	property p_report_display;
		snapshot_report_valid |=> display_snapshot_number == $past(snapshot_report_number);
	endproperty
	property p_alt_mask;
		block_alt_select[15:10] == 6'h00;
	endproperty
	property p_mute_split;
		(block_input_mute | block_output_mute) == block_bypass
			&& (block_input_mute & block_output_mute) == 16'h0000;
	endproperty
	a_step_up: assert property (p_step_up) else $error("step up missed");
	a_up_top: assert property (p_up_top) else $error("step up past eight");
	a_dn_bot: assert property (p_dn_bot) else $error("step down past one");
	a_select: assert property (p_select) else $error("direct select wrong");
	a_step_low: assert property (p_step_low) else $error("low step acted");
	a_report_display: assert property (p_report_display) else $error("display lags");
	a_alt_mask: assert property (p_alt_mask) else $error("alt on plain block");
	a_mute_split: assert property (p_mute_split) else $error("mute split wrong");
endmodule
bind pss_snapshot_selector pss_monitor u_monitor (.*);

// ---- dv/test_preset_snapshot_selector.sv ----
// self-checking bench for the snapshot selector
`timescale 1ns/1ps
module test_preset_snapshot_selector;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        midi_cc_valid, midi_pc_valid, local_footswitch_input;
	logic [6:0]  midi_cc_number, midi_cc_value, midi_pc_number, preset_load_index;
	logic [15:0] block_bypass, block_alt_select, block_input_mute, block_output_mute;
	logic [7:0]  main_level, external_insert_path_level;
	logic [3:0]  display_snapshot_number, snapshot_report_number;
	logic        snapshot_report_valid, preset_load_valid, preset_store_valid;
	int          failures = 0, cmp_count = 0, store_cnt = 0, load_cnt = 0;
	// entries: controller number, value, expected display
	logic [17:0] steps [15] = '{
		{pss_pkg::RESET_SELECT_CC, 7'h00, 4'h1}, {pss_pkg::RESET_SELECT_CC, 7'h09, 4'h2},
		{pss_pkg::RESET_SELECT_CC, 7'h7F, 4'h8}, {pss_pkg::RESET_SELECT_CC, 7'h3F, 4'h8},
		{pss_pkg::RESET_SELECT_CC, 7'h40, 4'h1}, {pss_pkg::RESET_SELECT_CC, 7'h64, 4'h5},
		{pss_pkg::RESET_UP_CC, 7'h3F, 4'h5}, {pss_pkg::RESET_UP_CC, 7'h40, 4'h6},
		{pss_pkg::RESET_UP_CC, 7'h7F, 4'h7}, {pss_pkg::RESET_UP_CC, 7'h40, 4'h8},
		{pss_pkg::RESET_UP_CC, 7'h7F, 4'h8}, {pss_pkg::RESET_DOWN_CC, 7'h00, 4'h8},
		{pss_pkg::RESET_DOWN_CC, 7'h40, 4'h7}, {pss_pkg::RESET_SELECT_CC, 7'h08, 4'h1},
		{pss_pkg::RESET_DOWN_CC, 7'h7F, 4'h1}};
	pss_snapshot_selector dut (.*);
	pss_midi_model midi (.*);
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (preset_store_valid === 1'b1) store_cnt <= store_cnt + 1;
		if (preset_load_valid === 1'b1) load_cnt <= load_cnt + 1;
	end
	// ====
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// valid and payload hold until the edge at which ready was seen high
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_t, w_t, b_t;
		n = 0;
		b_t = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t && n < 100) begin
			#1;
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!b_t) failures++;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar_t, r_t;
		n = 0;
		r_t = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t && n < 100) begin
			#1;
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!r_t) failures++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
		check(32'(rs), 32'(pss_pkg::RESP_OKAY));
	endtask
	task automatic settle();
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic sel(input logic [6:0] v);
		midi.send_cc(pss_pkg::RESET_SELECT_CC, v);
		settle();
	endtask
	// ====
	// tests
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		axi_rd(pss_pkg::CCNUM_OFFSET, rd, rs);
		check(rd, 32'h007C7B22);
		check(32'(main_level), 32'h80);
		axi_rd(8'h40, rd, rs);
		check(32'(rs), 32'(pss_pkg::RESP_SLVERR));
		axi_wr(8'h44, 32'h1, rs);
		check(32'(rs), 32'(pss_pkg::RESP_SLVERR));
		foreach (steps[i]) begin
			midi.send_cc(steps[i][17:11], steps[i][10:4]);
			settle();
			check(32'(display_snapshot_number), 32'(steps[i][3:0]));
		end
		for (int i = 0; i < 8; i++) begin
			wr(pss_pkg::CMD_OFFSET, 32'h8 | (i << 4));
			settle();
			check(32'(display_snapshot_number), 32'(i + 1));
		end
		$display("test selection done");
		wr(pss_pkg::BYPASS_OFFSET, 32'h3);
		wr(pss_pkg::MUTE_OFFSET, 32'h1);
		wr(pss_pkg::LEVEL_OFFSET, 32'h3344);
		wr(pss_pkg::ALT_OFFSET, 32'hFFFF);
		settle();
		check(32'(block_alt_select), 32'h03FF);
		check(32'(block_input_mute), 32'h1);
		check(32'(block_output_mute), 32'h2);
		check({main_level, external_insert_path_level}, 32'h4433);
		sel(7'h00);
		check({block_bypass, main_level}, 32'h80);
		sel(7'h07);
		check(32'(block_bypass), 32'h3);
		wr(pss_pkg::CTRL_OFFSET, 32'h1);
		sel(7'h00);
		sel(7'h07);
		check(32'(block_bypass), 32'h0);
		wr(pss_pkg::BYPASS_OFFSET, 32'h5);
		wr(pss_pkg::CMD_OFFSET, 32'h1);
		settle();
		check(store_cnt, 32'h1);
		sel(7'h00);
		sel(7'h07);
		check(32'(block_bypass), 32'h5);
		wr(pss_pkg::CTRL_OFFSET, 32'h0);
		wr(pss_pkg::BYPASS_OFFSET, 32'h9);
		wr(pss_pkg::CMD_OFFSET, 32'h4);
		settle();
		check({load_cnt[27:0], display_snapshot_number}, 32'h11);
		sel(7'h07);
		check(32'(block_bypass), 32'h5);
		$display("test edits done");
		wr(pss_pkg::MAP_OFFSET, 32'h00030505);
		wr(pss_pkg::CTRL_OFFSET, 32'h4);
		midi.send_pc(7'h05);
		settle();
		check({load_cnt[27:0], display_snapshot_number}, 32'h24);
		check(32'(preset_load_index), 32'h5);
		axi_rd(pss_pkg::STATUS_OFFSET, rd, rs);
		check(rd, 32'h0503);
		wr(pss_pkg::MAP_OFFSET, 32'h00060506);
		wr(pss_pkg::CTRL_OFFSET, 32'h6);
		midi.send_pc(7'h06);
		settle();
		check({load_cnt[27:0], display_snapshot_number}, 32'h27);
		axi_rd(pss_pkg::MAP_OFFSET, rd, rs);
		check(rd, 32'h00060506);
		$display("test program change done");
		midi.set_local_footswitch_input(1'b1);
		repeat (8) @(posedge core_clk);
		#1;
		check(32'(display_snapshot_number), 32'h8);
		midi.set_local_footswitch_input(1'b0);
		repeat (8) @(posedge core_clk);
		#1;
		check(32'(display_snapshot_number), 32'h1);
		wr(pss_pkg::CMD_OFFSET, 32'h2);
		sel(7'h07);
		check({load_cnt[27:0], block_bypass[3:0]}, 32'h30);
		$display("test local_footswitch_input done");
		end_sim();
	end
	initial begin
		#1000000;
		failures++;
		end_sim();
	end
endmodule
